// [design/bdcf_map.vh]
// Command framing constants for the background debug command block
`ifndef BDCF_MAP_VH
`define BDCF_MAP_VH

// Field widths
`define BDCF_CMD_BITS      5'h08
`define BDCF_ADDR_BITS     5'h10
`define BDCF_BYTE_BITS     5'h08
`define BDCF_WORD_BITS     5'h10

// Delay element, in target debug clock cycles
`define BDCF_DELAY_CYCLES  5'h10

// Field codes of a command structure
`define BDCF_F_END         3'h0
`define BDCF_F_ADDR        3'h1
`define BDCF_F_WR8         3'h2
`define BDCF_F_WR16        3'h3
`define BDCF_F_RD8         3'h4
`define BDCF_F_WORD_READ_FIELD        3'h5
`define BDCF_F_DLY         3'h6

// Command codes, non-intrusive class
`define BDCF_OP_HALT       8'h90
`define BDCF_OP_RD_STAT    8'hE4
`define BDCF_OP_WR_CTRL    8'hC4
`define BDCF_OP_RD_BKPT    8'hE2
`define BDCF_OP_WR_BKPT    8'hC2
`define BDCF_OP_RD_BYTE    8'hE0
`define BDCF_OP_WR_BYTE    8'hC0
// Command codes, active background class
`define BDCF_OP_GO         8'h08
`define BDCF_OP_STEP       8'h10
`define BDCF_OP_TAG_GO     8'h18
`define BDCF_OP_RD_WORD    8'hE8
`define BDCF_OP_WR_WORD    8'hC8

// Status and control register bit positions
`define BDCF_SC_ENABLE     7
`define BDCF_SC_ACTIVE     6
`define BDCF_SC_BKPT_EN    5
`define BDCF_SC_WAIT       4

// Reset values
`define BDCF_SC_RST        8'h00
`define BDCF_BKPT_RST      16'h0000

`endif

// [design/bdcf_shift.v]
// MSB-first 16-bit shift register shared by receive and transmit fields
`timescale 1ns/1ps
module bdcf_shift (
  input  wire        clk_i,
  input  wire        srst_i,
  input  wire        load_i,
  input  wire [15:0] load_data_i,
  input  wire        shift_i,
  input  wire        bit_i,
  output wire [15:0] data_o
);

  reg [15:0] data_q;

  always @(posedge clk_i) begin
    if (srst_i) begin
      data_q <= 16'h0000;
    end else if (load_i) begin
      data_q <= load_data_i;
    end else if (shift_i) begin
      data_q <= {data_q[14:0], bit_i};
    end
  end

  assign data_o = data_q;

endmodule // bdcf_shift

// [design/bdcf_framer.v]
// Background debug command framing, target side
// Contract
// - all fields shift most significant bit first
// - active commands only while halted in background
// - delay element lasts 16 debug clock cycles
// - byte fields carry 8 bits each way
// - word fields carry 16 bits each way
// - status returns register, control writes 8 bits
// - breakpoint fields move 16 bits each way
// - halt in wait restarts clocks, enters background
// - leave background only on reset or resume
`timescale 1ns/1ps
`include "bdcf_map.vh"
module bdcf_framer (
  input  wire        clk_i,
  input  wire        srst_i,
  input  wire        rx_valid_i,
  input  wire        rx_bit_i,
  input  wire        tx_req_i,
  input  wire        cpu_wait_i,
  input  wire        cpu_bgnd_i,
  input  wire [15:0] mem_rdata_i,
  output reg         tx_bit_o,
  output reg         tx_valid_o,
  output reg         busy_o,
  output reg         bg_active_o,
  output reg         clk_restart_o,
  output reg         resume_o,
  output reg         resume_step_o,
  output reg         resume_tag_o,
  output reg         illegal_cmd_o,
  output reg         mem_req_o,
  output reg         mem_we_o,
  output reg         mem_word_o,
  output reg  [15:0] mem_addr_o,
  output reg  [15:0] mem_wdata_o,
  output reg  [15:0] bkpt_addr_o,
  output reg         bkpt_en_o,
  output reg         dbg_enable_o
);

  localparam [3:0] S_CMD   = 4'h1;
  localparam [3:0] S_NEXT  = 4'h2;
  localparam [3:0] S_FIELD = 4'h4;
  localparam [3:0] S_DELAY = 4'h8;

  // Status and control reset image, bit-selectable
  localparam [7:0] SC_RST  = `BDCF_SC_RST;

  ////////////////////////////////////////////////////////////////////////////
  // Command tables

  // Up to four fields after the code, first field in the top bits
  function [11:0] seq_of;
    input [7:0] c;
    begin
      case (c)
        `BDCF_OP_HALT:    seq_of = {`BDCF_F_DLY, 9'h000};
        `BDCF_OP_RD_STAT: seq_of = {`BDCF_F_RD8, 9'h000};
        `BDCF_OP_WR_CTRL: seq_of = {`BDCF_F_WR8, 9'h000};
        `BDCF_OP_RD_BKPT: seq_of = {`BDCF_F_WORD_READ_FIELD, 9'h000};
        `BDCF_OP_WR_BKPT: seq_of = {`BDCF_F_WR16, 9'h000};
        `BDCF_OP_RD_BYTE: seq_of = {`BDCF_F_ADDR, `BDCF_F_DLY,
                                    `BDCF_F_RD8, `BDCF_F_END};
        `BDCF_OP_WR_BYTE: seq_of = {`BDCF_F_ADDR, `BDCF_F_WR8,
                                    `BDCF_F_DLY, `BDCF_F_END};
        `BDCF_OP_GO:      seq_of = {`BDCF_F_DLY, 9'h000};
        `BDCF_OP_STEP:    seq_of = {`BDCF_F_DLY, 9'h000};
        `BDCF_OP_TAG_GO:  seq_of = {`BDCF_F_DLY, 9'h000};
        `BDCF_OP_RD_WORD: seq_of = {`BDCF_F_ADDR, `BDCF_F_DLY,
                                    `BDCF_F_WORD_READ_FIELD, `BDCF_F_END};
        `BDCF_OP_WR_WORD: seq_of = {`BDCF_F_ADDR, `BDCF_F_WR16,
                                    `BDCF_F_DLY, `BDCF_F_END};
        default:          seq_of = 12'h000;
      endcase
    end
  endfunction

  function [2:0] field_at;
    input [7:0] c;
    input [1:0] idx;
    reg   [11:0] s;
    begin
      s = seq_of(c);
      case (idx)
        2'h0:    field_at = s[11:9];
        2'h1:    field_at = s[8:6];
        2'h2:    field_at = s[5:3];
        default: field_at = s[2:0];
      endcase
    end
  endfunction

  function is_active_cmd;
    input [7:0] c;
    begin
      is_active_cmd = (c == `BDCF_OP_GO) || (c == `BDCF_OP_STEP) ||
                      (c == `BDCF_OP_TAG_GO) || (c == `BDCF_OP_RD_WORD) ||
                      (c == `BDCF_OP_WR_WORD);
    end
  endfunction

  // Field length less one, in bits
  function [4:0] last_bit;
    input [2:0] f;
    begin
      case (f)
        `BDCF_F_WR8, `BDCF_F_RD8: last_bit = `BDCF_BYTE_BITS - 5'h01;
        default:
          last_bit = `BDCF_WORD_BITS - 5'h01;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  reg [3:0]  state_q;
  reg [7:0]  cmd_q;
  reg [1:0]  idx_q;
  reg [4:0]  bitcnt_q;
  reg [4:0]  dly_q;
  reg        legal_q;
  reg [15:0] rdata_q;

  wire [15:0] sh_data;
  wire [2:0]  fld      = field_at(cmd_q, idx_q);
  wire        fld_rx   = (fld == `BDCF_F_ADDR) || (fld == `BDCF_F_WR8) ||
                         (fld == `BDCF_F_WR16);
  wire        fld_tx   = (fld == `BDCF_F_RD8) || (fld == `BDCF_F_WORD_READ_FIELD);
  wire        fld_last = (bitcnt_q == last_bit(fld));
  wire [15:0] rx_word  = {sh_data[14:0], rx_bit_i};
  wire [7:0]  cmd_word = rx_word[7:0];
  wire [7:0]  status   = {dbg_enable_o, bg_active_o, bkpt_en_o,
                          cpu_wait_i, 4'h0};
  wire        is_mem   = (cmd_q == `BDCF_OP_RD_BYTE) ||
                         (cmd_q == `BDCF_OP_WR_BYTE) ||
                         (cmd_q == `BDCF_OP_RD_WORD) ||
                         (cmd_q == `BDCF_OP_WR_WORD);
  wire        is_wr    = (cmd_q == `BDCF_OP_WR_BYTE) ||
                         (cmd_q == `BDCF_OP_WR_WORD);
  wire        is_word  = (cmd_q == `BDCF_OP_RD_WORD) ||
                         (cmd_q == `BDCF_OP_WR_WORD);

  // Load and shift controls for the shared shifter
  reg        sh_load;
  reg [15:0] sh_load_data;
  wire       sh_shift = ((state_q == S_CMD) && rx_valid_i) ||
                        ((state_q == S_FIELD) && fld_rx && rx_valid_i) ||
                        ((state_q == S_FIELD) && fld_tx && tx_req_i);
  wire       sh_bit   = (state_q == S_FIELD && fld_tx) ? 1'b0 : rx_bit_i;

  always @* begin
    sh_load      = 1'b0;
    sh_load_data = 16'h0000;
    if (state_q == S_NEXT && fld_tx) begin
      sh_load = 1'b1;
      if (!legal_q) begin
        sh_load_data = 16'h0000;
      end else if (cmd_q == `BDCF_OP_RD_STAT) begin
        sh_load_data = {8'h00, status};
      end else if (cmd_q == `BDCF_OP_RD_BKPT) begin
        sh_load_data = bkpt_addr_o;
      end else begin
        sh_load_data = rdata_q;
      end
    end
  end

  bdcf_shift u_shift (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .load_i      (sh_load),
    .load_data_i (sh_load_data),
    .shift_i     (sh_shift),
    .bit_i       (sh_bit),
    .data_o      (sh_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Framing sequencer

  always @(posedge clk_i) begin
    if (srst_i) begin
      state_q       <= S_CMD;
      cmd_q         <= 8'h00;
      idx_q         <= 2'h0;
      bitcnt_q      <= 5'h00;
      dly_q         <= 5'h00;
      legal_q       <= 1'b0;
      rdata_q       <= 16'h0000;
      tx_bit_o      <= 1'b0;
      tx_valid_o    <= 1'b0;
      busy_o        <= 1'b0;
      bg_active_o   <= 1'b0;
      clk_restart_o <= 1'b0;
      resume_o      <= 1'b0;
      resume_step_o <= 1'b0;
      resume_tag_o  <= 1'b0;
      illegal_cmd_o <= 1'b0;
      mem_req_o     <= 1'b0;
      mem_we_o      <= 1'b0;
      mem_word_o    <= 1'b0;
      mem_addr_o    <= 16'h0000;
      mem_wdata_o   <= 16'h0000;
      bkpt_addr_o   <= `BDCF_BKPT_RST;
      bkpt_en_o     <= SC_RST[`BDCF_SC_BKPT_EN];
      dbg_enable_o  <= SC_RST[`BDCF_SC_ENABLE];
    end else begin
      tx_valid_o    <= 1'b0;
      clk_restart_o <= 1'b0;
      resume_o      <= 1'b0;
      resume_step_o <= 1'b0;
      resume_tag_o  <= 1'b0;
      illegal_cmd_o <= 1'b0;
      mem_req_o     <= 1'b0;
      if (cpu_bgnd_i) begin
        bg_active_o <= 1'b1;
      end
      case (state_q)
        S_CMD: begin
          if (rx_valid_i) begin
            bitcnt_q <= bitcnt_q + 5'h01;
            if (bitcnt_q == `BDCF_CMD_BITS - 1) begin
              cmd_q    <= cmd_word;
              idx_q    <= 2'h0;
              bitcnt_q <= 5'h00;
              legal_q  <= !is_active_cmd(cmd_word) || bg_active_o;
              illegal_cmd_o <= is_active_cmd(cmd_word) && !bg_active_o;
              state_q  <= S_NEXT;
            end
          end
        end
        S_NEXT: begin
          bitcnt_q <= 5'h00;
          case (fld)
            `BDCF_F_END: begin
              state_q <= S_CMD;
              if (legal_q) begin
                case (cmd_q)
                  `BDCF_OP_HALT: begin
                    bg_active_o   <= 1'b1;
                    clk_restart_o <= cpu_wait_i;
                  end
                  `BDCF_OP_GO: begin
                    bg_active_o <= 1'b0;
                    resume_o    <= 1'b1;
                  end
                  `BDCF_OP_STEP: begin
                    bg_active_o   <= 1'b0;
                    resume_o      <= 1'b1;
                    resume_step_o <= 1'b1;
                  end
                  `BDCF_OP_TAG_GO: begin
                    bg_active_o  <= 1'b0;
                    resume_o     <= 1'b1;
                    resume_tag_o <= 1'b1;
                  end
                  default: begin
                  end
                endcase
              end
            end
            `BDCF_F_DLY: begin
              state_q <= S_DELAY;
              dly_q   <= 5'h00;
              busy_o  <= 1'b1;
              if (legal_q && is_mem) begin
                mem_req_o  <= 1'b1;
                mem_we_o   <= is_wr;
                mem_word_o <= is_word;
              end
            end
            default: begin
              state_q <= S_FIELD;
            end
          endcase
        end
        S_FIELD: begin
          if ((fld_rx && rx_valid_i) || (fld_tx && tx_req_i)) begin
            bitcnt_q <= bitcnt_q + 5'h01;
            if (fld_tx) begin
              tx_valid_o <= 1'b1;
              tx_bit_o   <= (fld == `BDCF_F_WORD_READ_FIELD) ? sh_data[15]
                                                  : sh_data[7];
            end
            if (fld_last) begin
              idx_q   <= idx_q + 2'h1;
              state_q <= S_NEXT;
              if (fld == `BDCF_F_ADDR) begin
                mem_addr_o <= rx_word;
              end else if (fld == `BDCF_F_WR8 && legal_q) begin
                if (cmd_q == `BDCF_OP_WR_CTRL) begin
                  dbg_enable_o <= rx_word[`BDCF_SC_ENABLE];
                  bkpt_en_o    <= rx_word[`BDCF_SC_BKPT_EN];
                end else begin
                  mem_wdata_o <= {8'h00, rx_word[7:0]};
                end
              end else if (fld == `BDCF_F_WR16 && legal_q) begin
                if (cmd_q == `BDCF_OP_WR_BKPT) begin
                  bkpt_addr_o <= rx_word;
                end else begin
                  mem_wdata_o <= rx_word;
                end
              end
            end
          end
        end
        S_DELAY: begin
          dly_q <= dly_q + 5'h01;
          if (dly_q == `BDCF_DELAY_CYCLES - 1) begin
            busy_o  <= 1'b0;
            idx_q   <= idx_q + 2'h1;
            state_q <= S_NEXT;
            if (legal_q && is_mem && !is_wr) begin
              rdata_q <= is_word ? mem_rdata_i : {8'h00, mem_rdata_i[7:0]};
            end
          end
        end
        default: begin
          state_q <= S_CMD;
        end
      endcase
    end
  end

endmodule // bdcf_framer

// [tb/bdcf_framer_properties.sv]
// Temporal checks on the framer ports
`timescale 1ns/1ps
module bdcf_framer_props (
  input logic clk_i,
  input logic srst_i,
  input logic tx_req_i,
  input logic cpu_wait_i,
  input logic tx_valid_o,
  input logic busy_o,
  input logic bg_active_o,
  input logic clk_restart_o,
  input logic resume_o,
  input logic resume_step_o,
  input logic resume_tag_o,
  input logic illegal_cmd_o,
  input logic mem_req_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  AST_TX_LAT: assert property (tx_valid_o |-> $past(tx_req_i))
    else $error("reply bit without request");
  AST_BUSY_LEN: assert property ($rose(busy_o) |->
    busy_o[*8] ##1 busy_o[*8] ##1 !busy_o)
    else $error("delay length wrong");
  AST_REQ_BUSY: assert property (mem_req_o |-> $rose(busy_o))
    else $error("access outside delay start");
  AST_EXIT: assert property ($fell(bg_active_o) && !$past(srst_i)
    |-> resume_o || $past(resume_o))
    else $error("left background without resume");
  AST_STEP: assert property (resume_step_o |->
    resume_o && !resume_tag_o)
    else $error("step flag without resume");
  AST_TAG: assert property (resume_tag_o |-> resume_o)
    else $error("tag flag without resume");
  AST_ILL: assert property (illegal_cmd_o |->
    !bg_active_o && !mem_req_o)
    else $error("refusal while halted");
  AST_RESTART: assert property (clk_restart_o |-> $past(cpu_wait_i))
    else $error("restart without wait");
  cover property (illegal_cmd_o);
  cover property (resume_step_o);
  cover property (mem_req_o);
endmodule // bdcf_framer_props

// [tb/bdcf_host.sv]
// Host pod model driving the debug pin bit layer
`timescale 1ns/1ps
module bdcf_host (
  input  logic clk_i,
  input  logic tx_bit_o,
  input  logic tx_valid_o,
  input  logic busy_o,
  output logic rx_valid_i,
  output logic rx_bit_i,
  output logic tx_req_i,
  output int   to_total
);
  initial begin
    rx_valid_i = 1'b0;
    rx_bit_i   = 1'b0;
    tx_req_i   = 1'b0;
    to_total   = 0;
  end
  // Idle line shows no stale bit
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk_i);
      rx_valid_i = 1'b0;
      rx_bit_i   = ~rx_bit_i;
      tx_req_i   = 1'b0;
    end
  endtask
  task automatic put(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge clk_i);
      rx_valid_i = 1'b1;
      rx_bit_i   = v[i];
    end
    idle(1);
  endtask
  task automatic get(output logic [15:0] v, input int n);
    v = 16'h0000;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_i);
      tx_req_i = 1'b1;
      @(negedge clk_i);
      tx_req_i = 1'b0;
      // Reply bit due one cycle after the request
      if (tx_valid_o !== 1'b1) to_total++;
      v = {v[14:0], tx_bit_o};
    end
    idle(1);
  endtask
  // Silent through the whole delay element
  task automatic dly();
    int k;
    k = 0;
    while (busy_o !== 1'b1 && k < 40) begin
      idle(1);
      k++;
    end
    while (busy_o === 1'b1 && k < 80) begin
      idle(1);
      k++;
    end
    if (k < 16 || k > 30) to_total++;
    idle(2);
  endtask
endmodule // bdcf_host

// [tb/tb_top.sv]
// Self-checking bench for the command framer
`timescale 1ns/1ps
`include "bdcf_map.vh"
`define CHK(a, b) begin \
  total_checks++; \
  if ((a) !== (b)) begin \
    err_total++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); \
  end \
end
module tb_top;
  typedef struct {
    logic [7:0]  op;
    logic [15:0] ad;
    logic [15:0] wd;
    logic [15:0] rd;
  } bdcf_row_t;
  logic clk_i, srst_i, rx_valid_i, rx_bit_i, tx_req_i;
  logic cpu_wait_i, cpu_bgnd_i, tx_bit_o, tx_valid_o, busy_o;
  logic bg_active_o, clk_restart_o, resume_o, resume_step_o;
  logic resume_tag_o, illegal_cmd_o, mem_req_o, mem_we_o;
  logic mem_word_o, bkpt_en_o, dbg_enable_o;
  logic [15:0] mem_rdata_i, mem_addr_o, mem_wdata_o, bkpt_addr_o, r;
  int err_total, total_checks, to_total;
  int n_rst, n_res, n_stp, n_tag, n_ill, n_req;
  bdcf_row_t rows [8] = '{
    '{`BDCF_OP_WR_CTRL, 16'h0000, 16'h00A0, 16'h0000},
    '{`BDCF_OP_RD_STAT, 16'h0000, 16'h0000, 16'h00E0},
    '{`BDCF_OP_WR_BKPT, 16'h0000, 16'h1234, 16'h0000},
    '{`BDCF_OP_RD_BKPT, 16'h0000, 16'h0000, 16'h1234},
    '{`BDCF_OP_WR_BYTE, 16'hA55A, 16'h003C, 16'h0000},
    '{`BDCF_OP_RD_BYTE, 16'h0102, 16'h0000, 16'h00EF},
    '{`BDCF_OP_WR_WORD, 16'h2000, 16'hCAFE, 16'h0000},
    '{`BDCF_OP_RD_WORD, 16'h2002, 16'h0000, 16'hBEEF}};
  bdcf_framer DUT (.*);
  bdcf_host host (.*);
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    n_rst <= n_rst + clk_restart_o;
    n_res <= n_res + resume_o;
    n_stp <= n_stp + resume_step_o;
    n_tag <= n_tag + resume_tag_o;
    n_ill <= n_ill + illegal_cmd_o;
    n_req <= n_req + mem_req_o;
  end
  task automatic end_sim();
    err_total += to_total;
    if (err_total == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [15:0] ad, wd);
    r = 16'h0000;
    host.put({8'h00, op}, 8);
    case (op)
      `BDCF_OP_RD_STAT: host.get(r, 8);
      `BDCF_OP_WR_CTRL: host.put(wd, 8);
      `BDCF_OP_RD_BKPT: host.get(r, 16);
      `BDCF_OP_WR_BKPT: host.put(wd, 16);
      `BDCF_OP_RD_BYTE, `BDCF_OP_RD_WORD: begin
        host.put(ad, 16);
        host.dly();
        host.get(r, op[3] ? 16 : 8);
      end
      `BDCF_OP_WR_BYTE, `BDCF_OP_WR_WORD: begin
        host.put(ad, 16);
        host.put(wd, op[3] ? 16 : 8);
        host.dly();
      end
      default: host.dly();
    endcase
    host.idle(2);
  endtask
  task automatic bgnd();
    @(negedge clk_i);
    cpu_bgnd_i = 1'b1;
    @(negedge clk_i);
    cpu_bgnd_i = 1'b0;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    end_sim();
  end
  initial begin
    {srst_i, cpu_wait_i, cpu_bgnd_i, mem_rdata_i} = {3'b110, 16'hBEEF};
    repeat (8) @(negedge clk_i);
    srst_i = 1'b0;
    `CHK(bg_active_o, 1'b0)
    cmd(`BDCF_OP_HALT, 16'h0000, 16'h0000);
    `CHK({bg_active_o, n_rst}, {1'b1, 32'd1})
    cpu_wait_i = 1'b0;
    foreach (rows[i]) begin
      cmd(rows[i].op, rows[i].ad, rows[i].wd);
      case (rows[i].op)
        `BDCF_OP_WR_CTRL: `CHK({dbg_enable_o, bkpt_en_o}, 2'b11)
        `BDCF_OP_WR_BKPT: `CHK(bkpt_addr_o, rows[i].wd)
        `BDCF_OP_WR_BYTE, `BDCF_OP_WR_WORD: begin
          `CHK({mem_we_o, mem_word_o}, {1'b1, rows[i].op[3]})
          `CHK({mem_addr_o, mem_wdata_o}, {rows[i].ad, rows[i].wd})
        end
        default: `CHK(r, rows[i].rd)
      endcase
    end
    `CHK(n_req, 4)
    cmd(`BDCF_OP_GO, 16'h0000, 16'h0000);
    `CHK({bg_active_o, n_res, n_stp}, {1'b0, 32'd1, 32'd0})
    cmd(`BDCF_OP_RD_STAT, 16'h0000, 16'h0000);
    `CHK(r, 16'h00A0)
    cmd(`BDCF_OP_RD_WORD, 16'h2002, 16'h0000);
    `CHK({r, n_ill, n_req}, {16'h0000, 32'd1, 32'd4})
    cmd(`BDCF_OP_WR_WORD, 16'h2000, 16'h1111);
    `CHK({mem_wdata_o, n_ill}, {16'hCAFE, 32'd2})
    bgnd();
    cmd(`BDCF_OP_STEP, 16'h0000, 16'h0000);
    `CHK({bg_active_o, n_res, n_stp}, {1'b0, 32'd2, 32'd1})
    bgnd();
    cmd(`BDCF_OP_TAG_GO, 16'h0000, 16'h0000);
    `CHK({n_res, n_tag}, {32'd3, 32'd1})
    cmd(`BDCF_OP_HALT, 16'h0000, 16'h0000);
    `CHK({bg_active_o, n_rst}, {1'b1, 32'd1})
    srst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    srst_i = 1'b0;
    `CHK({bg_active_o, dbg_enable_o, bkpt_addr_o}, 18'h0)
    end_sim();
  end
endmodule // tb_top
bind bdcf_framer bdcf_framer_props u_chk (.*);
